// ---- verilog/isvm_pkg.sv ----
package isvm_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_CH = 32;
    localparam int unsigned ID_W = 5;
    localparam int unsigned LVL_W = 3;
    localparam int unsigned NUM_LVL = 8;
    localparam int unsigned TYPE_W = 2;
    localparam int unsigned NUM_EVT = 3;

    localparam logic [ADDR_W-1:0] ADDR_PEND = 32'hB800_2108;
    localparam logic [ADDR_W-1:0] ADDR_VEC = 32'hB800_210C;
    localparam logic [ADDR_W-1:0] ADDR_SRCNUM = 32'hB800_2110;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 32'hB800_2114;
    localparam logic [ADDR_W-1:0] ADDR_LINES = 32'hB800_2118;
    localparam logic [ADDR_W-1:0] ADDR_MSET = 32'hB800_2120;
    localparam logic [ADDR_W-1:0] ADDR_MCLR = 32'hB800_2124;
    localparam logic [ADDR_W-1:0] ADDR_DONE = 32'hB800_2130;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 32'hB800_2140;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 32'hB800_2144;

    localparam int unsigned VEC_LSB = 2;
    localparam int unsigned LINE_FAST_BIT = 0;
    localparam int unsigned LINE_NORM_BIT = 1;
    localparam int unsigned EVT_FAST_BIT = 0;
    localparam int unsigned EVT_NORM_BIT = 1;
    localparam int unsigned EVT_DONE_BIT = 2;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
    localparam logic [ID_W-1:0] NO_VECTOR = 5'h00;
    localparam logic [LVL_W-1:0] LVL_TOP = 3'h0;
    localparam logic [LVL_W:0] LVL_NONE = 4'h8;

    typedef enum logic [TYPE_W-1:0] {
        ISVM_LOW_LEVEL = 2'b00,
        ISVM_HIGH_LEVEL = 2'b01,
        ISVM_FALL_EDGE = 2'b10,
        ISVM_RISE_EDGE = 2'b11
    } isvm_trig_e;
endpackage : isvm_pkg

// ---- verilog/isvm_top.sv ----
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module isvm_top (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [isvm_pkg::ADDR_W-1:0] i_addr,
    input wire logic [isvm_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [isvm_pkg::NUM_CH-1:0] i_raw_level,
    input wire logic [isvm_pkg::NUM_CH*isvm_pkg::TYPE_W-1:0] i_source_trigger_type,
    input wire logic [isvm_pkg::NUM_CH*isvm_pkg::LVL_W-1:0] i_prio_level,
    output logic [isvm_pkg::DATA_W-1:0] o_rdata,
    output logic o_normal_request_line,
    output logic o_fast_request_line,
    output logic o_irq
);
    localparam int unsigned NCH = isvm_pkg::NUM_CH;
    localparam int unsigned LW = isvm_pkg::LVL_W;
    localparam int unsigned IW = isvm_pkg::ID_W;
    localparam int unsigned NE = isvm_pkg::NUM_EVT;
    localparam int unsigned VEC_MSB = isvm_pkg::VEC_LSB + IW - 1;

    logic [NCH-1:0] raw_prev_q;
    logic [NCH-1:0] edge_flag_q;
    logic [NCH-1:0] active;
    logic [NCH-1:0] channel_enable_bit_q;
    logic [NCH-1:0] pending_enabled_bit;
    logic [IW-1:0] vector_q;
    logic [LW-1:0] vec_lvl_q;
    logic [IW-1:0] winning_channel_id_q;
    logic [isvm_pkg::NUM_LVL-1:0] in_service_q;
    logic normal_line_q;
    logic fast_line_q;
    logic [NE-1:0] evt_stat_q;
    logic [NE-1:0] evt_mask_q;
    logic [NE-1:0] evt_set;
    logic irq_q;
    logic [isvm_pkg::DATA_W-1:0] rdata_q;

    logic wr_mset;
    logic wr_mclr;
    logic wr_done;
    logic wr_emask;
    logic rd_vec;
    logic rd_estat;
    logic [LW:0] thresh;
    logic win_found;
    logic [IW-1:0] win_ch;
    logic [LW-1:0] win_lvl;
    logic vec_load;

    assign wr_mset = i_wr && (i_addr == isvm_pkg::ADDR_MSET);
    assign wr_mclr = i_wr && (i_addr == isvm_pkg::ADDR_MCLR);
    assign wr_done = i_wr && (i_addr == isvm_pkg::ADDR_DONE);
    assign wr_emask = i_wr && (i_addr == isvm_pkg::ADDR_EVT_MASK);
    assign rd_vec = i_rd && (i_addr == isvm_pkg::ADDR_VEC);
    assign rd_estat = i_rd && (i_addr == isvm_pkg::ADDR_EVT_STAT);

    // per-channel activity from trigger type; mask plays no part here
    genvar g;
    generate
        // bit 0 runs too but never wins: its mask bit stays zero
        for (g = 0; g < NCH; g++) begin : g_ch
            isvm_pkg::isvm_trig_e ttype;
            logic rise;
            logic fall;
            logic edge_hit;
            logic edge_clr;
            assign ttype = isvm_pkg::isvm_trig_e'(
                i_source_trigger_type[g*isvm_pkg::TYPE_W +: isvm_pkg::TYPE_W]);
            assign rise = i_raw_level[g] && !raw_prev_q[g];
            assign fall = !i_raw_level[g] && raw_prev_q[g];
            assign edge_hit = (ttype == isvm_pkg::ISVM_RISE_EDGE) ? rise :
                (ttype == isvm_pkg::ISVM_FALL_EDGE) ? fall : 1'b0;
            // edge flags clear once their vector has been taken
            assign edge_clr = rd_vec && (vector_q == IW'(g));

            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    raw_prev_q[g] <= 1'b0;
                    edge_flag_q[g] <= 1'b0;
                end else if (i_ce) begin
                    raw_prev_q[g] <= i_raw_level[g];
                    if (edge_hit) begin
                        edge_flag_q[g] <= 1'b1;
                    end else if (edge_clr) begin
                        edge_flag_q[g] <= 1'b0;
                    end
                end
            end

            always_comb begin
                case (ttype)
                    isvm_pkg::ISVM_LOW_LEVEL: active[g] = !i_raw_level[g];
                    isvm_pkg::ISVM_HIGH_LEVEL: active[g] = i_raw_level[g];
                    default: active[g] = edge_flag_q[g];
                endcase
            end
        end
    endgenerate

    assign pending_enabled_bit = active & channel_enable_bit_q;

    // mask: set wins over clear when both hit the same bit in one cycle
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            channel_enable_bit_q <= isvm_pkg::RESET_WORD;
        end else if (i_ce) begin
            if (wr_mset) begin
                channel_enable_bit_q <= channel_enable_bit_q | {i_wdata[NCH-1:1], 1'b0};
            end else if (wr_mclr) begin
                channel_enable_bit_q <= channel_enable_bit_q & ~{i_wdata[NCH-1:1], 1'b0};
            end
        end
    end

    // nesting threshold: only levels above the highest one in service
    always_comb begin
        thresh = isvm_pkg::LVL_NONE;
        for (int i = isvm_pkg::NUM_LVL - 1; i >= 0; i--) begin
            if (in_service_q[i]) begin
                thresh = (LW+1)'(i);
            end
        end
    end

    always_comb begin
        win_found = 1'b0;
        win_ch = isvm_pkg::NO_VECTOR;
        win_lvl = LW'(isvm_pkg::NUM_LVL - 1);
        for (int c = 1; c < NCH; c++) begin
            if (pending_enabled_bit[c] &&
                ({1'b0, i_prio_level[c*LW +: LW]} < thresh) &&
                (!win_found || (i_prio_level[c*LW +: LW] < win_lvl))) begin
                win_found = 1'b1;
                win_ch = IW'(c);
                win_lvl = i_prio_level[c*LW +: LW];
            end
        end
    end

    // a new vector is latched only while none is outstanding
    assign vec_load = win_found && (vector_q == isvm_pkg::NO_VECTOR) && !rd_vec;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            vector_q <= isvm_pkg::NO_VECTOR;
            vec_lvl_q <= isvm_pkg::LVL_TOP;
            winning_channel_id_q <= isvm_pkg::NO_VECTOR;
        end else if (i_ce) begin
            if (rd_vec) begin
                vector_q <= isvm_pkg::NO_VECTOR;
            end else if (vec_load) begin
                vector_q <= win_ch;
                vec_lvl_q <= win_lvl;
                winning_channel_id_q <= win_ch;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            fast_line_q <= 1'b0;
            normal_line_q <= 1'b0;
        end else if (i_ce) begin
            if (rd_vec) begin
                fast_line_q <= 1'b0;
                normal_line_q <= 1'b0;
            end else if (vec_load) begin
                fast_line_q <= (win_lvl == isvm_pkg::LVL_TOP);
                normal_line_q <= (win_lvl != isvm_pkg::LVL_TOP);
            end
        end
    end

    // acknowledge marks a level in service, end of service retires the top
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            in_service_q <= '0;
        end else if (i_ce) begin
            if (rd_vec && (vector_q != isvm_pkg::NO_VECTOR)) begin
                in_service_q[vec_lvl_q] <= 1'b1;
            end else if (wr_done && (thresh != isvm_pkg::LVL_NONE)) begin
                in_service_q[thresh[LW-1:0]] <= 1'b0;
            end
        end
    end

    // event flags: new events win over the clearing read
    assign evt_set = {wr_done, vec_load && (win_lvl != isvm_pkg::LVL_TOP),
                      vec_load && (win_lvl == isvm_pkg::LVL_TOP)};

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            evt_stat_q <= '0;
            evt_mask_q <= '0;
            irq_q <= 1'b0;
        end else if (i_ce) begin
            evt_stat_q <= (rd_estat ? '0 : evt_stat_q) | evt_set;
            if (wr_emask) begin
                evt_mask_q <= i_wdata[NE-1:0];
            end
            // one cycle behind the flags, so a read-clear drops it next edge
            irq_q <= |(evt_stat_q & evt_mask_q);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rdata_q <= isvm_pkg::RESET_WORD;
        end else if (i_ce) begin
            rdata_q <= isvm_pkg::RESET_WORD;
            if (i_rd) begin
                case (i_addr)
                    isvm_pkg::ADDR_PEND: rdata_q <= pending_enabled_bit;
                    isvm_pkg::ADDR_VEC: rdata_q[VEC_MSB:isvm_pkg::VEC_LSB] <= vector_q;
                    isvm_pkg::ADDR_SRCNUM: rdata_q[IW-1:0] <= winning_channel_id_q;
                    isvm_pkg::ADDR_MASK: rdata_q <= channel_enable_bit_q;
                    isvm_pkg::ADDR_LINES: begin
                        rdata_q[isvm_pkg::LINE_NORM_BIT] <= normal_line_q;
                        rdata_q[isvm_pkg::LINE_FAST_BIT] <= fast_line_q;
                    end
                    isvm_pkg::ADDR_EVT_STAT: rdata_q[NE-1:0] <= evt_stat_q;
                    isvm_pkg::ADDR_EVT_MASK: rdata_q[NE-1:0] <= evt_mask_q;
                    default: rdata_q <= isvm_pkg::RESET_WORD;
                endcase
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_normal_request_line = normal_line_q;
    assign o_fast_request_line = fast_line_q;
    assign o_irq = irq_q;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_status_and_mask: assert property (
        pending_enabled_bit[NCH-1:1] ==
            (active[NCH-1:1] & channel_enable_bit_q[NCH-1:1]))
        else $error("pending status not active and enabled");

    a_vector_read_clear: assert property (
        i_ce && rd_vec |=> vector_q == isvm_pkg::NO_VECTOR)
        else $error("vector not cleared after read");

    a_read_returns_vec: assert property (
        i_ce && rd_vec |=> o_rdata[VEC_MSB:isvm_pkg::VEC_LSB] == $past(vector_q))
        else $error("vector read data wrong");

    a_fast_line_level: assert property (
        i_ce && vec_load |=> fast_line_q == (vec_lvl_q == isvm_pkg::LVL_TOP)
            && normal_line_q == !fast_line_q)
        else $error("line class does not match winner level");

    a_srcnum_copy: assert property (
        i_ce && vec_load |=> winning_channel_id_q == vector_q)
        else $error("source number differs from vector");

    a_vector_enabled: assert property (
        i_ce && vec_load |-> channel_enable_bit_q[win_ch] && active[win_ch])
        else $error("vector given to a disabled or idle channel");

    a_mask_set_cmd: assert property (
        i_ce && wr_mset |=> (channel_enable_bit_q[NCH-1:1] &
            $past(i_wdata[NCH-1:1])) == $past(i_wdata[NCH-1:1]))
        else $error("mask set command missed a channel");

    a_mask_clr_cmd: assert property (
        i_ce && wr_mclr |=> (channel_enable_bit_q[NCH-1:1] &
            $past(i_wdata[NCH-1:1])) == '0)
        else $error("mask clear command missed a channel");

    a_done_retires: assert property (
        i_ce && wr_done && !rd_vec && thresh != isvm_pkg::LVL_NONE
            |=> !in_service_q[$past(thresh[LW-1:0])])
        else $error("end of service left level in service");

    a_done_event: assert property (
        i_ce && wr_done |=> evt_stat_q[isvm_pkg::EVT_DONE_BIT])
        else $error("end of service event not flagged");

    a_priority_order: assert property (
        vec_load |-> !(win_ch > 1 && pending_enabled_bit[1] &&
            i_prio_level[LW +: LW] <= win_lvl && {1'b0, i_prio_level[LW +: LW]} < thresh))
        else $error("lower channel at equal or higher level lost");

    a_lines_status: assert property (
        i_ce && i_rd && i_addr == isvm_pkg::ADDR_LINES |=>
            o_rdata[isvm_pkg::LINE_NORM_BIT] == $past(normal_line_q) &&
            o_rdata[isvm_pkg::LINE_FAST_BIT] == $past(fast_line_q))
        else $error("output status bits wrong");
endmodule : isvm_top

// ---- verif/isvm_core_model.sv ----
`timescale 1ns/10ps
module isvm_core_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_normal_request_line,
    input wire logic i_fast_request_line,
    output logic [7:0] o_normal_taken,
    output logic [7:0] o_fast_taken
);
    logic normal_q;
    logic fast_q;

    // a level request is entered once per rise of its line
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            normal_q <= 1'b0;
            fast_q <= 1'b0;
            o_normal_taken <= 8'h00;
            o_fast_taken <= 8'h00;
        end else begin
            normal_q <= i_normal_request_line;
            fast_q <= i_fast_request_line;
            if (i_normal_request_line && !normal_q) begin
                o_normal_taken <= o_normal_taken + 8'h01;
            end
            if (i_fast_request_line && !fast_q) begin
                o_fast_taken <= o_fast_taken + 8'h01;
            end
        end
    end
endmodule : isvm_core_model

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] i_raw_level = 32'h0;
    logic [63:0] i_source_trigger_type = {32{2'h1}};
    logic [95:0] i_prio_level = {32{3'h7}};
    logic [31:0] o_rdata;
    logic o_normal_request_line;
    logic o_fast_request_line;
    logic o_irq;
    logic [7:0] normal_taken;
    logic [7:0] fast_taken;
    int num_errors = 0;
    int samples_checked = 0;

    always #12.5 i_ref_clk = ~i_ref_clk;

    isvm_top uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_raw_level(i_raw_level),
        .i_source_trigger_type(i_source_trigger_type),
        .i_prio_level(i_prio_level), .o_rdata(o_rdata),
        .o_normal_request_line(o_normal_request_line),
        .o_fast_request_line(o_fast_request_line), .o_irq(o_irq));

    isvm_core_model core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_normal_request_line(o_normal_request_line),
        .i_fast_request_line(o_fast_request_line),
        .o_normal_taken(normal_taken), .o_fast_taken(fast_taken));

    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [31:0] a,
                          input logic [31:0] exp);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk_word(what, exp, o_rdata);
    endtask : rd_chk

    // sel: 0 normal line, 1 fast line, 2 event interrupt
    task automatic wait_for(input int sel, input logic v);
        logic s;
        for (int n = 0; n < 20; n++) begin
            s = (sel == 0) ? o_normal_request_line :
                (sel == 1) ? o_fast_request_line : o_irq;
            if (s === v) begin
                samples_checked++;
                return;
            end
            @(posedge i_ref_clk);
            #1;
        end
        num_errors++;
        $display("mismatch output %0d expected %b seen %b", sel, v, s);
        give_verdict();
    endtask : wait_for

    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        rd_chk("pending", isvm_pkg::ADDR_PEND, 32'h0);
        rd_chk("vector", isvm_pkg::ADDR_VEC, 32'h0);
        rd_chk("source number", isvm_pkg::ADDR_SRCNUM, 32'h0);
        rd_chk("mask", isvm_pkg::ADDR_MASK, 32'h0);
        rd_chk("lines", isvm_pkg::ADDR_LINES, 32'h0);
        reg_wr(32'hB800_2200, 32'hFFFF_FFFF);
        rd_chk("unmapped", 32'hB800_2200, 32'h0);
        $display("test reset done");
        // only channels backed by real sources are enabled
        reg_wr(isvm_pkg::ADDR_MSET, 32'h184);
        reg_wr(isvm_pkg::ADDR_MSET, 32'h8);
        reg_wr(isvm_pkg::ADDR_MCLR, 32'h104);
        reg_wr(isvm_pkg::ADDR_MASK, 32'hFFFF_FFFF);
        rd_chk("mask", isvm_pkg::ADDR_MASK, 32'h88);
        reg_wr(isvm_pkg::ADDR_EVT_MASK, 32'h2);
        $display("test mask done");
        i_prio_level[9 +: 3] <= 3'h2;
        i_prio_level[21 +: 3] <= 3'h2;
        i_prio_level[36 +: 3] <= 3'h0;
        i_raw_level <= 32'h1088;
        wait_for(0, 1'b1);
        rd_chk("lines", isvm_pkg::ADDR_LINES, 32'h2);
        rd_chk("pending", isvm_pkg::ADDR_PEND, 32'h88);
        rd_chk("source number", isvm_pkg::ADDR_SRCNUM, 32'h3);
        wait_for(2, 1'b1);
        rd_chk("event status", isvm_pkg::ADDR_EVT_STAT, 32'h2);
        wait_for(2, 1'b0);
        rd_chk("vector", isvm_pkg::ADDR_VEC, 32'hC);
        chk_word("normal line", 32'h0, {31'h0, o_normal_request_line});
        // channel 7 shares the serviced level, so it stays held off
        rd_chk("vector", isvm_pkg::ADDR_VEC, 32'h0);
        reg_wr(isvm_pkg::ADDR_DONE, 32'hDEAD_BEEF);
        wait_for(0, 1'b1);
        rd_chk("vector", isvm_pkg::ADDR_VEC, 32'hC);
        $display("test arbitration done");
        reg_wr(isvm_pkg::ADDR_MCLR, 32'h88);
        reg_wr(isvm_pkg::ADDR_MSET, 32'h1000);
        wait_for(1, 1'b1);
        rd_chk("lines", isvm_pkg::ADDR_LINES, 32'h1);
        rd_chk("source number", isvm_pkg::ADDR_SRCNUM, 32'hC);
        rd_chk("vector", isvm_pkg::ADDR_VEC, 32'h30);
        reg_wr(isvm_pkg::ADDR_DONE, 32'h0);
        reg_wr(isvm_pkg::ADDR_DONE, 32'hFFFF_FFFF);
        wait_for(1, 1'b1);
        i_source_trigger_type[26 +: 2] <= 2'h0;
        reg_wr(isvm_pkg::ADDR_MSET, 32'h2000);
        rd_chk("pending", isvm_pkg::ADDR_PEND, 32'h3000);
        chk_word("normal taken", 32'h2, {24'h0, normal_taken});
        chk_word("fast taken", 32'h2, {24'h0, fast_taken});
        $display("test nesting done");
        wait_for(2, 1'b1);
        reg_wr(isvm_pkg::ADDR_EVT_MASK, 32'h0);
        wait_for(2, 1'b0);
        reg_wr(isvm_pkg::ADDR_EVT_MASK, 32'h2);
        wait_for(2, 1'b1);
        rd_chk("event mask", isvm_pkg::ADDR_EVT_MASK, 32'h2);
        rd_chk("event status", isvm_pkg::ADDR_EVT_STAT, 32'h7);
        wait_for(2, 1'b0);
        $display("test events done");
        give_verdict();
    end
endmodule : testbench
